// file: hdl/compare_and_pwm_output.sv
// compare and pwm output stage of one capture/compare/pwm channel
// assumes timebase count comes from logic on the same clock
// Notes on behaviour
// (R1) writing all-zero control forces compare output latch low
// (R2) timebase must run synchronously for compare matching
// (R3) timebase must not run from the raw core clock
// (R4) software interrupt mode leaves the pin to its other function
// (R5) compare need not work while the clock is stopped
// (R6) modes 1011 and 1010 output high only while count equals compare
// (R7) modes 0001 and 0010 toggle output on each match
// (R8) mode 1001 clears, mode 1000 sets output on match
// (R9) channel output fans out to internal peripherals and pin
// (R10) standard pwm gives up to 10-bit resolution on pin
// (R11) pwm timing comes only from timer period, control, duty pair
// (R12) all-zero control releases the pin
// (R13) software setup order for pwm
// (R14) wait for timer overflow before enabling pin driver; pin_oe_n_o goes low as soon as pwm mode is written, with no wait
// (R15) any of three period timers selectable as pwm base
// (R16) after period match: reload timer, set pin unless duty zero, latch duty
// (R17) 10-bit base compared with buffered duty clears pin
// (R18) alignment bit picks where the 10-bit duty sits in the pair
// (R19) every compare match sets the match flag until cleared
// (R20) matches and latch registered; reset zeroes latch, mode, duty buffer
`timescale 1ns/1ns
`default_nettype none
module compare_and_pwm_output
  import ccp_out_pkg::*;
#(
  parameter int NUM_TIMERS = ccp_out_pkg::NUM_TMR
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // channel control register
  input wire logic ctrl_we_i,
  input wire logic [7:0] channel_control_reg_i,
  input wire logic [ccp_out_pkg::CNT_W-1:0] compare_value_pair_i,
  // timebases
  input wire logic [ccp_out_pkg::CNT_W-1:0] timebase16_count_i,
  input wire logic [ccp_out_pkg::SEL_W-1:0] pwm_timer_select_i,
  input wire logic [NUM_TIMERS*ccp_out_pkg::PER_W-1:0] period_limit_reg_i,
  input wire logic [NUM_TIMERS-1:0] period_timer_on_i,
  // match flag
  input wire logic match_flag_clr_i,
  output logic match_flag_o,
  // outputs
  output logic channel_out_o,
  output logic pin_out_o,
  output logic pin_oe_n_o,
  output logic [ccp_out_pkg::PER_W+1:0] sel_base_o,
  output logic [7:0] ctrl_o
);
  import ccp_out_pkg::*;

  logic [7:0] ctrl_q, ctrl_d;
  logic out_q, out_d;
  logic flag_q, flag_d;
  logic hit_q, hit_d;
  logic [DUTY_W-1:0] duty_q, duty_d;
  logic [NUM_TIMERS*(PER_W+2)-1:0] bases;
  logic [NUM_TIMERS-1:0] wraps;
  logic [PER_W+1:0] base;
  logic wrap;
  logic [3:0] mode;
  logic match;
  logic [DUTY_W-1:0] duty_new;
  op_t op;

  // one timer per selectable base
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    period_timer #(.PER_W(PER_W)) u_tmr (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .on_i(period_timer_on_i[i]),
      .period_i(period_limit_reg_i[i*PER_W +: PER_W]),
      .base_o(bases[i*(PER_W+2) +: PER_W+2]),
      .wrap_o(wraps[i])
    );
  end

  // out-of-range select falls back to timer 0
  always_comb begin
    base = bases[0 +: PER_W+2]; // R15
    wrap = wraps[0];
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (32'(pwm_timer_select_i) == i) begin
        base = bases[i*(PER_W+2) +: PER_W+2];
        wrap = wraps[i];
      end
    end
  end

  assign mode = ctrl_q[3:0];
  assign match = (timebase16_count_i == compare_value_pair_i);

  always_comb begin
    if (!ctrl_q[EN_BIT] || mode == MODE_OFF) begin
      op = OP_IDLE;
    end else if (mode == MODE_PWM) begin
      op = OP_PWM;
    end else begin
      op = OP_CMP;
    end
  end

  // duty alignment: left-justified puts msbs in the high word
  always_comb begin
    if (ctrl_q[FMT_BIT]) begin
      duty_new = compare_value_pair_i[15:6]; // R18
    end else begin
      duty_new = compare_value_pair_i[9:0]; // R18
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    out_d = out_q;
    duty_d = duty_q;
    hit_d = 1'b0;
    flag_d = flag_q;
    if (match_flag_clr_i) begin
      flag_d = 1'b0;
    end
    unique case (op)
      OP_IDLE: begin
        out_d = 1'b0;
      end
      OP_CMP: begin
        hit_d = match; // R20
        // edge on match so a slow timebase fires once per match
        if (match && !hit_q) begin
          flag_d = 1'b1; // R19
          if (mode == MODE_TOG_A || mode == MODE_TOG_B) begin
            out_d = ~out_q; // R7
          end else if (mode == MODE_CLR) begin
            out_d = 1'b0; // R8
          end else if (mode == MODE_SET) begin
            out_d = 1'b1; // R8
          end
        end
        if (mode == MODE_SWI || mode == MODE_TRIG) begin
          out_d = match; // R6
        end
      end
      OP_PWM: begin
        if (wrap) begin
          duty_d = duty_new; // R16
          out_d = (duty_new != '0); // R16
        end else if (base == duty_q) begin
          out_d = 1'b0; // R17
        end
      end
    endcase
    if (ctrl_we_i) begin
      ctrl_d = channel_control_reg_i;
      if (channel_control_reg_i == CTRL_RESET) begin
        out_d = 1'b0; // R1
      end
    end
  end

  // state moves on clock edges only, so a stopped clock freezes compare
  always_ff @(posedge ref_clk_i) begin // R5
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RESET; // R20
      out_q <= 1'b0;
      duty_q <= DUTY_RESET;
      flag_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      out_q <= out_d;
      duty_q <= duty_d;
      flag_q <= flag_d;
      hit_q <= hit_d;
    end
  end

  assign channel_out_o = out_q; // R9
  assign pin_out_o = out_q; // R10
  // swi mode and idle leave the pin alone
  assign pin_oe_n_o = (op == OP_IDLE) || (op == OP_CMP && mode == MODE_SWI); // R4 R12
  assign match_flag_o = flag_q;
  assign sel_base_o = base; // R11
  assign ctrl_o = {ctrl_q[7], 1'b0, out_q, ctrl_q[4:0]};

  property p_clear_low;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ctrl_we_i && channel_control_reg_i == 8'h00 |=> !channel_out_o && pin_oe_n_o;
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("zero control did not clear output"); // R1 R12

  property p_swi_pin;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ctrl_q[7] && mode == 4'ha |-> pin_oe_n_o;
  endproperty
  a_swi_pin: assert property (p_swi_pin) else $error("swi mode drove the pin"); // R4

  property p_pulse;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      op == OP_CMP && (mode == 4'ha || mode == 4'hb) && !ctrl_we_i |=> channel_out_o == $past(match);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse output not tracking match"); // R6

  property p_toggle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      op == OP_CMP && (mode == 4'h1 || mode == 4'h2) && match && !hit_q && !ctrl_we_i
      |=> channel_out_o != $past(channel_out_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed"); // R7

  property p_setclr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      op == OP_CMP && match && !hit_q && !ctrl_we_i && (mode == 4'h8 || mode == 4'h9)
      |=> channel_out_o == ($past(mode) == 4'h8);
  endproperty
  a_setclr: assert property (p_setclr) else $error("set or clear on match wrong"); // R8

  property p_flag;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      op == OP_CMP && match && !hit_q |=> match_flag_o;
  endproperty
  a_flag: assert property (p_flag) else $error("match flag not set"); // R19

  property p_wrap;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      op == OP_PWM && wrap && !ctrl_we_i |=> duty_q == $past(duty_new) && channel_out_o == ($past(duty_new) != 10'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("period wrap handling wrong"); // R16

  property p_duty_end;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      op == OP_PWM && !wrap && base == duty_q && !ctrl_we_i |=> !channel_out_o;
  endproperty
  a_duty_end: assert property (p_duty_end) else $error("pwm did not clear at duty"); // R17
endmodule : compare_and_pwm_output
`default_nettype wire

// file: hdl/period_timer.sv
// one 8-bit auto-reload period timer with 2-bit sub-count
// assumes on_i and period_i come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module period_timer #(
  parameter int PER_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic on_i,
  input wire logic [PER_W-1:0] period_i,
  // state
  output logic [PER_W+1:0] base_o,
  output logic wrap_o
);
  logic [PER_W+1:0] base_q, base_d;
  logic wrap_q, wrap_d;
  always_comb begin
    base_d = base_q;
    wrap_d = 1'b0;
    if (on_i) begin
      // wrap after the last sub-step of the terminal count
      if (base_q[PER_W+1:2] == period_i && base_q[1:0] == 2'h3) begin
        base_d = '0;
        wrap_d = 1'b1;
      end else begin
        base_d = base_q + 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      base_q <= '0;
      wrap_q <= 1'b0;
    end else begin
      base_q <= base_d;
      wrap_q <= wrap_d;
    end
  end
  assign base_o = base_q;
  assign wrap_o = wrap_q;
endmodule : period_timer
`default_nettype wire

// file: include/ccp_out_pkg.sv
// constants for the compare/pwm output channel
// assumes a single system clock and synchronous reset
package ccp_out_pkg;
  localparam int CNT_W = 16;
  localparam int PER_W = 8;
  localparam int DUTY_W = 10;
  localparam int MODE_W = 4;
  localparam int NUM_TMR = 3;
  localparam int SEL_W = 2;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOG_A = 4'h1;
  localparam logic [3:0] MODE_TOG_B = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLR = 4'h9;
  localparam logic [3:0] MODE_SWI = 4'ha;
  localparam logic [3:0] MODE_TRIG = 4'hb;
  localparam logic [3:0] MODE_PWM = 4'hf;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int FMT_BIT = 4;
  localparam int EN_BIT = 7;
  localparam logic [9:0] DUTY_RESET = 10'h000;
  typedef enum logic [1:0] {OP_IDLE, OP_CMP, OP_PWM} op_t;
endpackage : ccp_out_pkg

// file: test/compare_and_pwm_output_tb.sv
// self-checking bench for the compare/pwm output channel
// assumes one clock, sync reset, pin model on the pad
`timescale 1ns/1ns
`default_nettype none
module compare_and_pwm_output_tb;
  import ccp_out_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, fclr = 1'b0, chk_on = 1'b0;
  logic [7:0] ctrl = 8'h00, m_ctl = 8'h00;
  logic [15:0] cmp = 16'h0000, cnt = 16'h0001;
  logic [1:0] sel = 2'h0;
  logic [23:0] per = 24'h000000;
  logic [2:0] ton = 3'h7;
  logic flag, cout, pout, oe_n, pin;
  logic [9:0] base;
  logic [7:0] rb;
  logic [31:0] lfsr = 32'h66a5;
  logic m_out = 1'b0, m_flag = 1'b0, m_prev = 1'b0, m_rel = 1'b1;
  logic [7:0] modes [6] = '{8'h88, 8'h89, 8'h81, 8'h82, 8'h8a, 8'h8b};
  int mismatches = 0, compares = 0, cyc = 0;
  compare_and_pwm_output i_compare_and_pwm_output (.ref_clk_i(clk), .rst_n_i(rst_n), .ctrl_we_i(we),
    .channel_control_reg_i(ctrl), .compare_value_pair_i(cmp), .timebase16_count_i(cnt),
    .pwm_timer_select_i(sel), .period_limit_reg_i(per), .period_timer_on_i(ton),
    .match_flag_clr_i(fclr), .match_flag_o(flag), .channel_out_o(cout), .pin_out_o(pout),
    .pin_oe_n_o(oe_n), .sel_base_o(base), .ctrl_o(rb));
  pin_model i_pin_model (.pin_out_i(pout), .pin_oe_n_i(oe_n), .pin_o(pin));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic results;
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (e !== g) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] v);
    @(posedge clk) ctrl <= v;
    we <= 1'b1;
    @(posedge clk) we <= 1'b0;
  endtask : wr
  // timebase held at the compare value for n cycles, then moved away at random
  task automatic mt(input int n);
    @(posedge clk) cnt <= cmp;
    repeat (n) @(posedge clk);
    lfsr = nxt(lfsr);
    cnt <= cmp ^ (lfsr[15:0] | 16'h0001);
    repeat (3) @(posedge clk);
  endtask : mt
  // cycles from one rising pin edge to the next, and high cycles among them
  task automatic rise(output int len, output int hi);
    logic pv;
    len = 0;
    hi = 0;
    forever begin
      pv = pout;
      @(negedge clk);
      len++;
      if (pout === 1'b1) hi++;
      if ((pout === 1'b1 && pv !== 1'b1) || len > 2100) break;
    end
  endtask : rise
  task automatic pwm(input logic [1:0] s, input logic [7:0] p, input logic [9:0] d, input logic fmt);
    logic [23:0] pv;
    int len, hi;
    wr(8'h00);
    lfsr = nxt(lfsr);
    pv = lfsr[23:0];
    pv[8*(s%3) +: 8] = p;
    sel <= s;
    per <= pv;
    cmp <= fmt ? {d, lfsr[5:0]} : {lfsr[31:26], d};
    // no wait for a first full period; the first one is discarded instead
    wr({1'b1, 2'b00, fmt, MODE_PWM});
    rise(len, hi);
    if (d != 10'h000) rise(len, hi);
    // a zero duty never raises the pin, so rise runs into its limit
    chk("period", d != 10'h000 ? 16'(4 * (p + 1)) : 16'd2101, 16'(len));
    chk("duty", 16'(d), 16'(hi));
    chk("oe_n", 16'h0000, {15'h0, oe_n});
    chk("pin", {15'h0, d != 10'h000}, {15'h0, pin});
    chk("chan", {15'h0, d != 10'h000}, {15'h0, cout});
    if (d != 10'h000) chk("base", 16'h0001, {6'h0, base});
    wr(8'h00);
    @(negedge clk) chk("released", 16'h0002, {14'h0, oe_n, pin});
  endtask : pwm
  always @(posedge clk) begin : model
    logic hit;
    cyc <= cyc + 1;
    hit = cnt === cmp && m_ctl[7] && m_ctl[3:0] != MODE_OFF && m_ctl[3:0] != MODE_PWM;
    if (!rst_n) begin
      m_out = 1'b0;
      m_flag = 1'b0;
      m_ctl = 8'h00;
    end else begin
      if (hit) m_flag = 1'b1;
      else if (fclr) m_flag = 1'b0;
      if (m_ctl[3:0] == MODE_SWI || m_ctl[3:0] == MODE_TRIG) m_out = hit;
      else if (hit && !m_prev) begin
        if (m_ctl[3:0] == MODE_TOG_A || m_ctl[3:0] == MODE_TOG_B) m_out = !m_out;
        else m_out = m_ctl[3:0] == MODE_SET;
      end
      if (we) begin
        m_ctl = ctrl;
        if (ctrl == 8'h00) m_out = 1'b0;
      end
    end
    m_prev = hit;
    if (cyc > 20000) begin
      mismatches++;
      results();
    end
  end
  always @(negedge clk) begin
    if (chk_on) begin
      chk("out", {15'h0, m_out}, {15'h0, cout});
      chk("flag", {15'h0, m_flag}, {15'h0, flag});
      chk("ctrl", {8'h0, m_ctl[7], 1'b0, m_out, m_ctl[4:0]}, {8'h0, rb});
      m_rel = !m_ctl[7] || m_ctl[3:0] == MODE_OFF || m_ctl[3:0] == MODE_SWI;
      chk("pin", {15'h0, m_rel ? 1'b0 : m_out}, {15'h0, pin});
      chk("oe_n", {15'h0, m_rel}, {15'h0, oe_n});
    end
  end
  initial begin
    repeat (19) @(posedge clk);
    @(negedge clk) chk("reset", 16'h0100, {4'h0, flag, cout, pout, oe_n, rb});
    @(posedge clk) rst_n <= 1'b1;
    chk_on = 1'b1;
    foreach (modes[i]) begin
      lfsr = nxt(lfsr);
      cmp <= lfsr[15:0];
      if (modes[i] != 8'h89) wr(8'h00);
      wr(modes[i]);
      mt(1);
      mt(2);
      mt(1);
      @(posedge clk) fclr <= 1'b1;
      @(posedge clk) fclr <= 1'b0;
    end
    chk_on = 1'b0;
    pwm(2'h0, 8'h0f, 10'd20, 1'b0);
    // duty kept below the 32-cycle period so the pin falls in every period
    pwm(2'h1, 8'h07, {6'h0, lfsr[3:0]} + 10'd1, 1'b1);
    pwm(2'h2, 8'hff, 10'h3ff, 1'b0);
    pwm(2'h3, 8'h03, 10'd5, 1'b1);
    pwm(2'h1, 8'h03, 10'h000, 1'b0);
    results();
  end
endmodule : compare_and_pwm_output_tb
`default_nettype wire

// file: test/pin_model.sv
// far side of the channel pin: a pad with a weak pull-down
// assumes oe_n low means the channel drives the pad
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  // channel side
  input wire logic pin_out_i,
  input wire logic pin_oe_n_i,
  // pad level
  output logic pin_o
);
  // released pad falls to the pull-down, never keeps the last value
  assign pin_o = pin_oe_n_i ? 1'b0 : pin_out_i;
endmodule : pin_model
`default_nettype wire
